//--- design/aidr_diag_record.v
// Purpose: Read-only diagnostic record of a two-channel analog current input.
// Assumes: All inputs are synchronous to clk; reset stands for power-on.
// Notes: The record is a snapshot taken when a diagnostic event is recorded.
//
// Overview of operation
// - Summary byte: bit0 failure, bit1 internal, bit2 external, bit3 any channel error.
// - Summary bit4 flags missing auxiliary supply; bits 6 and 5 read zero.
// - Summary bit7 flags a parameterization error.
// - Module info bits 3..0 read 0101b for analog; bits 7..5 read zero.
// - Module info bit4 set when channel diagnostic information is present.
// - Extended byte bit3 flags diagnostics buffer overflow; other low bits zero.
// - Extended byte bit4 flags an internal communication error.
// - Channel kind bits 6..0 read 71h, analog input.
// - Diagnostic bit count reads constant 08h.
// - Channel count reads constant 02h.
// - Group error bit0 and bit1 flag errors in channel groups 0 and 1.
// - Channel error bit0 flags a parameter error; bits 5..1 read zero.
// - Channel error bit6 flags input below measuring range.
// - Channel error bit7 flags input above measuring range.
// - Timestamp bytes capture the microsecond ticker when the event is recorded.
// - Ticker starts at zero on power-on and counts once per microsecond.
// - Ticker wraps to zero after its 32-bit maximum and keeps counting.
// - No interrupt; channel errors light the channel indicator and enter the record.
// - Six spare channel error bytes read as zero.
`include "aidr_regs.vh"

module aidr_diag_record (
  clk,
  reset,
  ce,
  module_fail,
  internal_err,
  external_err,
  aux_supply_missing,
  parm_err,
  diag_buf_overflow,
  comm_err,
  chan_parm_err,
  chan_under,
  chan_over,
  rd_addr,
  rd_data,
  chan_led,
  diag_pending,
  ticker
);
  input wire clk;
  input wire reset;
  input wire ce;
  input wire module_fail;
  input wire internal_err;
  input wire external_err;
  input wire aux_supply_missing;
  input wire parm_err;
  input wire diag_buf_overflow;
  input wire comm_err;
  input wire [1:0] chan_parm_err;
  input wire [1:0] chan_under;
  input wire [1:0] chan_over;
  input wire [4:0] rd_addr;
  output reg [7:0] rd_data;
  output reg [1:0] chan_led;
  output reg diag_pending;
  output reg [31:0] ticker;

  ////////////////////////////////////////////////////////////////////////////
  // Microsecond ticker.
  reg [7:0] pre_q;
  reg [31:0] tick_q;
  wire us_tick = (pre_q == `AIDR_TICK_CYC - 1);

  always @(posedge clk) begin
    if (reset) begin
      pre_q <= 8'h00;
      tick_q <= 32'h00000000;
    end else if (ce) begin
      pre_q <= us_tick ? 8'h00 : pre_q + 8'h01;
      if (us_tick) begin
        // Natural overflow of the 32-bit adder gives the wrap.
        tick_q <= tick_q + 32'h00000001;
      end
    end
  end

  always @* begin
    ticker = tick_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Live error state, assembled per channel.
  wire [7:0] ch_live [0:1];
  wire [1:0] ch_any;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_ch
      assign ch_live[g] = {chan_over[g],
                           chan_under[g],
                           5'h00,
                           chan_parm_err[g]};
      assign ch_any[g] = chan_over[g] | chan_under[g] | chan_parm_err[g];
    end
  endgenerate

  wire chan_err = |ch_any;
  wire [7:0] sum_live = {parm_err,
                         2'h0,
                         aux_supply_missing,
                         chan_err,
                         external_err,
                         internal_err,
                         module_fail};
  wire [7:0] ext_live = {3'h0, comm_err, diag_buf_overflow, 3'h0};

  ////////////////////////////////////////////////////////////////////////////
  // Snapshot. A change in the error picture is a diagnostic event; the
  // whole record is retaken together so the timestamp matches the bits.
  reg [7:0] sum_q;
  reg [7:0] ext_q;
  reg [7:0] ch0_q;
  reg [7:0] ch1_q;
  reg [31:0] ts_q;
  // Each byte is compared on its own, because folding the summary and extended
  // bytes together would let a swap between two overlapping bits go unseen.
  wire event_now = (sum_live != sum_q) || (ext_live != ext_q) ||
                   (ch_live[0] != ch0_q) || (ch_live[1] != ch1_q);

  always @(posedge clk) begin
    if (reset) begin
      sum_q <= `AIDR_ZERO8;
      ext_q <= `AIDR_ZERO8;
      ch0_q <= `AIDR_ZERO8;
      ch1_q <= `AIDR_ZERO8;
      ts_q <= 32'h00000000;
      diag_pending <= 1'b0;
      chan_led <= 2'h0;
    end else if (ce) begin
      chan_led <= ch_any;
      diag_pending <= event_now;
      if (event_now) begin
        sum_q <= sum_live;
        ext_q <= ext_live;
        ch0_q <= ch_live[0];
        ch1_q <= ch_live[1];
        ts_q <= tick_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Record read port. There is no write path at all.
  wire info_present = |{ch0_q, ch1_q};

  always @(posedge clk) begin
    if (reset) begin
      rd_data <= `AIDR_ZERO8;
    end else if (ce) begin
      case (rd_addr)
        `AIDR_OFF_SUMMARY: rd_data <= sum_q;
        `AIDR_OFF_MODINFO: rd_data <= {3'h0, info_present, `AIDR_MOD_CLASS};
        `AIDR_OFF_EXTDIAG: rd_data <= ext_q;
        `AIDR_OFF_CHKIND: rd_data <= {1'b0, `AIDR_KIND_AI};
        `AIDR_OFF_DIAG_BITS_PER_CHANNEL: rd_data <= `AIDR_DIAG_BITS_PER_CHANNEL_VAL;
        `AIDR_OFF_CHANNEL_COUNT: rd_data <= `AIDR_CHANNEL_COUNT_VAL;
        `AIDR_OFF_GRPERR: rd_data <= {6'h00, |ch1_q, |ch0_q};
        `AIDR_OFF_CHAN0_ERROR: rd_data <= ch0_q;
        `AIDR_OFF_CHAN1_ERROR: rd_data <= ch1_q;
        `AIDR_OFF_TS0: rd_data <= ts_q[7:0];
        `AIDR_OFF_TS1: rd_data <= ts_q[15:8];
        `AIDR_OFF_TS2: rd_data <= ts_q[23:16];
        `AIDR_OFF_TS3: rd_data <= ts_q[31:24];
        default: rd_data <= `AIDR_ZERO8;
      endcase
    end
  end
endmodule

//--- design/aidr_regs.vh
// Purpose: Constants of the analog input diagnostic record.
// Assumes: Byte offsets follow the record order; one clock of 200 MHz.
// Notes: Offsets are byte indices into the record read port.
`ifndef AIDR_REGS_VH
`define AIDR_REGS_VH
`define AIDR_OFF_SUMMARY 5'h00
`define AIDR_OFF_MODINFO 5'h01
`define AIDR_OFF_RSVD_C 5'h02
`define AIDR_OFF_EXTDIAG 5'h03
`define AIDR_OFF_CHKIND 5'h04
`define AIDR_OFF_DIAG_BITS_PER_CHANNEL 5'h05
`define AIDR_OFF_CHANNEL_COUNT 5'h06
`define AIDR_OFF_GRPERR 5'h07
`define AIDR_OFF_CHAN0_ERROR 5'h08
`define AIDR_OFF_CHAN1_ERROR 5'h09
`define AIDR_OFF_SPARE_LO 5'h0A
`define AIDR_OFF_SPARE_HI 5'h0F
`define AIDR_OFF_TS0 5'h10
`define AIDR_OFF_TS1 5'h11
`define AIDR_OFF_TS2 5'h12
`define AIDR_OFF_TS3 5'h13
`define AIDR_SUM_FAIL 0
`define AIDR_SUM_INT 1
`define AIDR_SUM_EXT 2
`define AIDR_SUM_CHAN 3
`define AIDR_SUM_AUX 4
`define AIDR_SUM_PARM 7
`define AIDR_MOD_CLASS 4'h5
`define AIDR_EXT_OVF 3
`define AIDR_EXT_COMM 4
`define AIDR_KIND_AI 7'h71
`define AIDR_DIAG_BITS_PER_CHANNEL_VAL 8'h08
`define AIDR_CHANNEL_COUNT_VAL 8'h02
`define AIDR_CH_PARM 0
`define AIDR_CH_UNDER 6
`define AIDR_CH_OVER 7
`define AIDR_CLK_MHZ 200
`define AIDR_TICK_US 1
`define AIDR_TICK_CYC (`AIDR_CLK_MHZ * `AIDR_TICK_US)
`define AIDR_ZERO8 8'h00
`endif

//--- tb/aidr_diag_record_tb.sv
// Purpose: Self-checking bench of the diagnostic record.
// Assumes: A short ce pause precedes every error change.
// Notes: The model rebuilds the whole record after each change.
module aidr_diag_record_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, reset = 1'b1, ce = 1'b1, diag_pending;
  logic [12:0] v_q = 13'h0000;
  logic [7:0] d, c0, c1, g, rd_data;
  logic [7:0] exp_q [0:20];
  logic [4:0] rd_addr;
  logic [1:0] chan_led;
  logic [31:0] ticker, us = 0, ts = 0;
  integer error_cnt = 0, checks = 0, pre = 0, tmo = 0, i, a;
  initial forever #2.5 clk = ~clk;
  aidr_diag_record DUT (.clk(clk), .reset(reset), .ce(ce), .module_fail(v_q[12]),
    .internal_err(v_q[11]), .external_err(v_q[10]), .aux_supply_missing(v_q[9]),
    .parm_err(v_q[8]), .diag_buf_overflow(v_q[7]), .comm_err(v_q[6]),
    .chan_parm_err(v_q[5:4]), .chan_under(v_q[3:2]), .chan_over(v_q[1:0]),
    .rd_addr(rd_addr), .rd_data(rd_data), .chan_led(chan_led),
    .diag_pending(diag_pending), .ticker(ticker));
  aidr_reader rdr (.clk(clk), .rd_addr(rd_addr), .rd_data(rd_data));
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    tmo++;
    if (!reset && ce) pre = (pre == 199) ? 0 : pre + 1;
    if (!reset && ce && pre == 0) us++;
    if (tmo == 20000) begin
      error_cnt++;
      report_and_stop;
    end
  end
  task event_chk(input logic [12:0] v);
    logic chg;
    chg = (v != v_q);
    @(posedge clk) ce <= 1'b0;
    @(posedge clk) begin ce <= 1'b1; v_q <= v; end
    #1 if (chg) ts = us;
    @(posedge clk) #1 cmp(diag_pending, chg);
    cmp(chan_led, v[5:4] | v[3:2] | v[1:0]);
    c0 = {v[0], v[2], 5'h00, v[4]};
    c1 = {v[1], v[3], 5'h00, v[5]};
    g = {6'h00, |c1, |c0};
    exp_q = '{{v[8], 2'b00, v[9], |g, v[10], v[11], v[12]}, {3'h0, |g, 4'h5}, 8'h00,
      {3'h0, v[6], v[7], 3'h0}, 8'h71, 8'h08, 8'h02, g, c0, c1, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, ts[7:0], ts[15:8], ts[23:16], ts[31:24], 8'h00};
    for (a = 0; a < 21; a++) begin
      rdr.read(a[4:0], d);
      cmp(d, exp_q[a]);
    end
    cmp(ticker, us);
  endtask
  initial begin
    void'($urandom(17));
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    for (i = 0; i < 13; i++) event_chk(13'h0001 << i);
    event_chk(13'h0000);
    event_chk(13'h0000);
    for (i = 0; i < 10; i++) event_chk(13'($urandom));
    report_and_stop;
  end
endmodule
bind aidr_diag_record aidr_props chk (.*);

//--- tb/aidr_props.sv
// Purpose: Assertions on the record ports.
// Assumes: Inputs only change while ce is high.
// Notes: Ticker wrap lies beyond any run.
module aidr_props (
  input logic clk, reset, ce, diag_pending,
  input logic [1:0] chan_parm_err, chan_under, chan_over, chan_led,
  input logic [4:0] rd_addr,
  input logic [7:0] rd_data,
  input logic [31:0] ticker
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] gap_q;
  always @(posedge clk)
    gap_q <= (reset || $changed(ticker)) ? 8'h00 : gap_q + 8'(ce);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_kind; ce && rd_addr == 5'h04 |=> rd_data == 8'h71; endproperty
  a_kind: assert property (p_kind) else $error("kind byte wrong");
  property p_nbit; ce && rd_addr == 5'h05 |=> rd_data == 8'h08; endproperty
  a_nbit: assert property (p_nbit) else $error("bit count wrong");
  property p_nch; ce && rd_addr == 5'h06 |=> rd_data == 8'h02; endproperty
  a_nch: assert property (p_nch) else $error("channel count wrong");
  property p_spare; ce && rd_addr inside {[5'h0A:5'h0F]} |=> rd_data == 8'h00; endproperty
  a_spare: assert property (p_spare) else $error("spare byte not zero");
  property p_step; $changed(ticker) |-> ticker == $past(ticker) + 32'h1; endproperty
  a_step: assert property (p_step) else $error("ticker step wrong");
  property p_gap; gap_q <= 8'hC8; endproperty
  a_gap: assert property (p_gap) else $error("ticker stalled");
  property p_pend; ce && $changed(chan_over) |=> diag_pending; endproperty
  a_pend: assert property (p_pend) else $error("no snapshot pulse");
  property p_led; ce && !reset |=> chan_led == $past(chan_over | chan_under | chan_parm_err);
  endproperty
  a_led: assert property (p_led) else $error("channel led wrong");
  property p_ch0; ce && $past(ce) && rd_addr == 5'h08 && $stable({chan_over, chan_under,
    chan_parm_err}) |=> rd_data == {$past(chan_over[0]), $past(chan_under[0]), 5'h00,
    $past(chan_parm_err[0])}; endproperty
  a_ch0: assert property (p_ch0) else $error("channel 0 byte wrong");
endmodule

//--- tb/aidr_reader.sv
// Purpose: Reader on the far side of the record port.
// Assumes: One read at a time.
// Notes: The address stands until the byte is taken.
module aidr_reader (
  input logic clk,
  output logic [4:0] rd_addr,
  input logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rd_addr = 5'h00;
  task automatic read(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk) rd_addr <= a;
    @(posedge clk) #1 d = rd_data;
  endtask
endmodule
